// >>> rtl/tdc_channel.sv
// one tamper detection channel: trigger decode, sampling choice and latched flag
`timescale 1ns/1ps
module tdc_channel
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // configuration
   input  wire logic arm,
   input  wire logic switch_wiring_select,
   input  wire logic trigger_level_select,
   input  wire logic periodic_check_select,
   // timing
   input  wire logic osc_running,
   input  wire logic second_tick,
   // pin
   input  wire logic intrusion_input,
   // status
   output logic      intrusion_flag,
   output logic      event_pulse
);
   logic [tdc_pkg::SYNC_STAGES-1:0] sync;
   logic [tdc_pkg::SYNC_STAGES-1:0] next_sync;
   logic                            next_flag;
   logic                            next_event;
   logic                            at_level;
   logic                            periodic;
   logic                            look;

   always_comb
   begin
      next_sync = {sync[tdc_pkg::SYNC_STAGES-2:0], intrusion_input};   // R17
      // the pin shows the trigger level in both wirings; open switch lets the pull reach it
      at_level  = (sync[tdc_pkg::SYNC_STAGES-1] == trigger_level_select);   // R02 R11 R12
      // normally open never samples; stopped oscillator reverts to continuous
      periodic  = !switch_wiring_select && periodic_check_select && osc_running;   // R10 R13 R14 R15
      look      = periodic ? second_tick : 1'b1;   // R16
      next_event = arm && look && at_level && !intrusion_flag;   // R01 R07
      if (!arm)
      begin
         next_flag = 1'b0;   // R03 R06
      end
      else
      begin
         next_flag = intrusion_flag || (look && at_level);   // R01 R06 R16
      end
   end

   always_ff @(posedge clk)
   begin
      // keeps shifting in reset, so a zero reset value never poses as a low-level trigger
      sync <= next_sync;   // R17
      if (!rst_n)
      begin
         intrusion_flag <= 1'b0;
         event_pulse    <= 1'b0;
      end
      else
      begin
         intrusion_flag <= next_flag;
         event_pulse    <= next_event;
      end
   end

   flag_holds_a: assert property (@(posedge clk) disable iff (!rst_n)   // R06
      intrusion_flag && arm |=> intrusion_flag)
      else $error("flag dropped while armed");
   flag_clears_a: assert property (@(posedge clk) disable iff (!rst_n)   // R03
      !arm |=> !intrusion_flag)
      else $error("flag survived disarm");
   flag_needs_arm_a: assert property (@(posedge clk) disable iff (!rst_n)   // R01
      $rose(intrusion_flag) |-> $past(arm))
      else $error("flag set while disarmed");
   periodic_wait_a: assert property (@(posedge clk) disable iff (!rst_n)   // R13 R16
      $rose(intrusion_flag) && $past(periodic) |-> $past(second_tick))
      else $error("periodic check set flag off the tick");
   continuous_set_a: assert property (@(posedge clk) disable iff (!rst_n)   // R14 R15
      arm && !periodic && at_level |=> intrusion_flag)
      else $error("continuous check missed a trigger");
endmodule

// >>> rtl/tdc_pkg.sv
// package: register map, bit positions and settings for the tamper channels
package tdc_pkg;
   localparam logic [7:0] FLAGS_ADDR      = 8'h0F;
   localparam logic [7:0] CFG_ONE_ADDR    = 8'h14;
   localparam logic [7:0] CFG_TWO_ADDR    = 8'h15;
   // flag register bit positions
   localparam int         FLAG_ONE_BIT    = 0;
   localparam int         FLAG_TWO_BIT    = 1;
   // tamper config register bit positions
   localparam int         CFG_ARM_BIT     = 7;
   localparam int         CFG_IRQ_BIT     = 6;
   localparam int         CFG_WIRING_BIT  = 5;
   localparam int         CFG_LEVEL_BIT   = 4;
   localparam int         CFG_PERIODIC_BIT = 3;
   localparam logic [7:0] CFG_RESET       = 8'h00;
   localparam logic [7:0] CFG_WR_MASK     = 8'hF8;
   localparam logic [7:0] READ_ZERO       = 8'h00;
   // synchroniser depth
   localparam int         SYNC_STAGES     = 2;
endpackage

// >>> rtl/tdc_top.sv
// top: tamper register file, two channels and the shared interrupt output
`timescale 1ns/1ps
// What this block does
// [R01] Two channels each set their own flag from their own pin when armed.
// [R02] The trigger is a switch closing to a rail or a closed switch opening, per config bits.
// [R03] Arming enables detection and a flag only clears while its arm bit is zero.
// [R04] Software should disarm then rearm after changing a channel's configuration.
// [R05] Software clears the flag by disarming then rearms to detect again.
// [R06] The flag sets on an armed event, is read-only and sits in the flags register.
// [R07] With its interrupt enable set, a channel event drives the shared interrupt pin.
// [R08] On battery the interrupt only fires if the battery interrupt enable is set.
// [R09] Software should read the flags register before disarming and rearming.
// [R10] The wiring bit picks normally open at one and normally closed at zero.
// [R11] The level bit picks trigger high at one and trigger low at zero.
// [R12] Wiring and level bits together give the four connection options.
// [R13] Normally closed wiring can check once a second or continuously.
// [R14] Normally open wiring ignores the periodic bit and watches continuously.
// [R15] Periodic checking needs the oscillator and reverts to continuous if it stops.
// [R16] The periodic strobe is the seconds tick and one sample at level sets the flag.
// [R17] Pin levels are synchronised before they can set a flag.
module tdc_top
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // system status
   input  wire logic       osc_running,
   input  wire logic       second_tick,
   input  wire logic       on_battery,
   input  wire logic       battery_irq_enable,
   // tamper pins
   input  wire logic       first_intrusion_input,
   input  wire logic       second_intrusion_input,
   // outputs
   output logic            irq_out_n,
   output logic            first_intrusion_flag,
   output logic            second_intrusion_flag
);
   logic [7:0] tamper_one_config;
   logic [7:0] tamper_two_config;
   logic [7:0] next_one_config;
   logic [7:0] next_two_config;
   logic [7:0] next_rdata;
   logic       next_irq_n;
   logic [1:0] flag;
   logic [1:0] event_pulse;
   logic [7:0] event_flags;
   logic       irq_ok;

   function automatic logic [7:0] cfg_write(input logic [7:0] old, input logic hit);
      cfg_write = hit ? (reg_wdata & tdc_pkg::CFG_WR_MASK) : old;
   endfunction

   always_comb
   begin
      next_one_config = cfg_write(tamper_one_config, reg_wr && reg_addr == tdc_pkg::CFG_ONE_ADDR);
      next_two_config = cfg_write(tamper_two_config, reg_wr && reg_addr == tdc_pkg::CFG_TWO_ADDR);
      event_flags = tdc_pkg::READ_ZERO;
      event_flags[tdc_pkg::FLAG_ONE_BIT] = flag[0];   // R06
      event_flags[tdc_pkg::FLAG_TWO_BIT] = flag[1];   // R06
      case (reg_addr)
         tdc_pkg::FLAGS_ADDR:   next_rdata = event_flags;
         tdc_pkg::CFG_ONE_ADDR: next_rdata = tamper_one_config;
         tdc_pkg::CFG_TWO_ADDR: next_rdata = tamper_two_config;
         default:               next_rdata = tdc_pkg::READ_ZERO;
      endcase
      if (!reg_rd)
      begin
         next_rdata = reg_rdata;
      end
      irq_ok = !on_battery || battery_irq_enable;   // R08
      // level irq held while an enabled flag stands
      next_irq_n = !(irq_ok &&
                   ((event_pulse[0] || flag[0]) && tamper_one_config[tdc_pkg::CFG_IRQ_BIT] ||
                    (event_pulse[1] || flag[1]) && tamper_two_config[tdc_pkg::CFG_IRQ_BIT]));   // R07
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         tamper_one_config     <= tdc_pkg::CFG_RESET;
         tamper_two_config     <= tdc_pkg::CFG_RESET;
         reg_rdata             <= tdc_pkg::READ_ZERO;
         irq_out_n             <= 1'b1;
         first_intrusion_flag  <= 1'b0;
         second_intrusion_flag <= 1'b0;
      end
      else
      begin
         tamper_one_config     <= next_one_config;
         tamper_two_config     <= next_two_config;
         reg_rdata             <= next_rdata;
         irq_out_n             <= next_irq_n;
         first_intrusion_flag  <= flag[0];
         second_intrusion_flag <= flag[1];
      end
   end

   tdc_channel u_first
   (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .arm                   (tamper_one_config[tdc_pkg::CFG_ARM_BIT]),
      .switch_wiring_select  (tamper_one_config[tdc_pkg::CFG_WIRING_BIT]),
      .trigger_level_select  (tamper_one_config[tdc_pkg::CFG_LEVEL_BIT]),
      .periodic_check_select (tamper_one_config[tdc_pkg::CFG_PERIODIC_BIT]),
      .osc_running           (osc_running),
      .second_tick           (second_tick),
      .intrusion_input       (first_intrusion_input),
      .intrusion_flag        (flag[0]),
      .event_pulse           (event_pulse[0])
   );

   tdc_channel u_second
   (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .arm                   (tamper_two_config[tdc_pkg::CFG_ARM_BIT]),
      .switch_wiring_select  (tamper_two_config[tdc_pkg::CFG_WIRING_BIT]),
      .trigger_level_select  (tamper_two_config[tdc_pkg::CFG_LEVEL_BIT]),
      .periodic_check_select (tamper_two_config[tdc_pkg::CFG_PERIODIC_BIT]),
      .osc_running           (osc_running),
      .second_tick           (second_tick),
      .intrusion_input       (second_intrusion_input),
      .intrusion_flag        (flag[1]),
      .event_pulse           (event_pulse[1])
   );

   // register file checks
   flag_readonly_a: assert property (@(posedge clk) disable iff (!rst_n)   // R06
      reg_wr && reg_addr == tdc_pkg::FLAGS_ADDR && flag[0] &&
      tamper_one_config[tdc_pkg::CFG_ARM_BIT] |=> flag[0])
      else $error("flag register write altered a flag");

   flag_readonly_two_a: assert property (@(posedge clk) disable iff (!rst_n)   // R06
      reg_wr && reg_addr == tdc_pkg::FLAGS_ADDR && flag[1] &&
      tamper_two_config[tdc_pkg::CFG_ARM_BIT] |=> flag[1])
      else $error("flag register write altered a flag");

   cfg_write_one_a: assert property (@(posedge clk) disable iff (!rst_n)   // R02
      reg_wr && reg_addr == tdc_pkg::CFG_ONE_ADDR
      |=> tamper_one_config == ($past(reg_wdata) & tdc_pkg::CFG_WR_MASK))
      else $error("first config write did not land");

   cfg_write_two_a: assert property (@(posedge clk) disable iff (!rst_n)   // R02
      reg_wr && reg_addr == tdc_pkg::CFG_TWO_ADDR
      |=> tamper_two_config == ($past(reg_wdata) & tdc_pkg::CFG_WR_MASK))
      else $error("second config write did not land");

   cfg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)   // R02
      !reg_wr |=> $stable(tamper_one_config) && $stable(tamper_two_config))
      else $error("config changed without a write");

   // reserved bits never store, so a read-back cannot leak stale write data
   cfg_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)   // R02
      (tamper_one_config & ~tdc_pkg::CFG_WR_MASK) == tdc_pkg::READ_ZERO &&
      (tamper_two_config & ~tdc_pkg::CFG_WR_MASK) == tdc_pkg::READ_ZERO)
      else $error("reserved config bit stored");

   read_config_one_a: assert property (@(posedge clk) disable iff (!rst_n)   // R02
      reg_rd && reg_addr == tdc_pkg::CFG_ONE_ADDR
      |=> reg_rdata == $past(tamper_one_config))
      else $error("first config read mismatch");

   read_config_two_a: assert property (@(posedge clk) disable iff (!rst_n)   // R02
      reg_rd && reg_addr == tdc_pkg::CFG_TWO_ADDR
      |=> reg_rdata == $past(tamper_two_config))
      else $error("second config read mismatch");

   flag_read_a: assert property (@(posedge clk) disable iff (!rst_n)   // R06
      reg_rd && reg_addr == tdc_pkg::FLAGS_ADDR
      |=> reg_rdata[tdc_pkg::FLAG_ONE_BIT] == $past(flag[0]) &&
          reg_rdata[tdc_pkg::FLAG_TWO_BIT] == $past(flag[1]))
      else $error("flags read did not show the flags");

   read_hold_a: assert property (@(posedge clk) disable iff (!rst_n)   // R06
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");

   // interrupt checks
   irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)   // R08
      on_battery && !battery_irq_enable |=> irq_out_n)
      else $error("irq raised on battery without enable");

   irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)   // R07
      !tamper_one_config[tdc_pkg::CFG_IRQ_BIT] && !tamper_two_config[tdc_pkg::CFG_IRQ_BIT]
      |=> irq_out_n)
      else $error("irq raised with both enables clear");

   irq_fires_a: assert property (@(posedge clk) disable iff (!rst_n)   // R07
      flag[0] && tamper_one_config[tdc_pkg::CFG_IRQ_BIT] && !on_battery |=> !irq_out_n)
      else $error("enabled flag did not raise irq");

   irq_fires_two_a: assert property (@(posedge clk) disable iff (!rst_n)   // R07
      flag[1] && tamper_two_config[tdc_pkg::CFG_IRQ_BIT] && !on_battery |=> !irq_out_n)
      else $error("enabled second flag did not raise irq");

   irq_battery_a: assert property (@(posedge clk) disable iff (!rst_n)   // R08
      flag[1] && tamper_two_config[tdc_pkg::CFG_IRQ_BIT] && on_battery &&
      battery_irq_enable |=> !irq_out_n)
      else $error("battery irq enable did not pass the irq");

   irq_needs_flag_a: assert property (@(posedge clk) disable iff (!rst_n)   // R07
      !flag[0] && !flag[1] && !event_pulse[0] && !event_pulse[1]
      |=> irq_out_n)
      else $error("irq raised with no flag standing");

   disarm_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)   // R03
      !tamper_one_config[tdc_pkg::CFG_ARM_BIT] && !tamper_two_config[tdc_pkg::CFG_ARM_BIT]
      |-> ##2 irq_out_n)
      else $error("irq outlived disarm of both channels");

   // pin copies lag the internal flags by one register
   flag_copy_one_a: assert property (@(posedge clk) disable iff (!rst_n)   // R06
      flag[0] |=> first_intrusion_flag)
      else $error("first flag pin did not follow");

   flag_copy_two_a: assert property (@(posedge clk) disable iff (!rst_n)   // R06
      flag[1] |=> second_intrusion_flag)
      else $error("second flag pin did not follow");
endmodule

// >>> testbench/tamper_detect_channels_bench.sv
// register-level tests of the two tamper channels
`timescale 1ns/1ps
module tamper_detect_channels_bench;
   logic       clk;
   logic       rst_n;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic       osc_running;
   logic       second_tick;
   logic       on_battery;
   logic       battery_irq_enable;
   logic [1:0] tripped;
   logic [1:0] level;
   logic [1:0] pin;
   logic       irq_out_n;
   logic [1:0] flag;
   int         n_fail;
   int         tests_run;
   int         cycles;

   tdc_switch_model sw_u (.tripped(tripped), .level(level), .pin(pin));
   tdc_top dut_u
   (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .osc_running(osc_running), .second_tick(second_tick), .on_battery(on_battery),
      .battery_irq_enable(battery_irq_enable), .first_intrusion_input(pin[0]),
      .second_intrusion_input(pin[1]), .irq_out_n(irq_out_n),
      .first_intrusion_flag(flag[0]), .second_intrusion_flag(flag[1])
   );

   always #5 clk = ~clk;

   task wrap_up;
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 5000)
      begin
         n_fail++;
         wrap_up();
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   // status byte: irq_out_n, then the two flag pins
   task st(input logic [7:0] exp);
      idle(6);
      chk({5'h00, irq_out_n, flag}, exp);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // quiet cycle, so a following call never re-raises the strobe in the same step
      @(negedge clk);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      chk(reg_rdata, exp);
      @(negedge clk);
   endtask

   initial
   begin
      {clk, rst_n, reg_wr, reg_rd, second_tick, on_battery, battery_irq_enable} = 7'h00;
      {reg_addr, reg_wdata, tripped, level} = 20'h00000;
      osc_running = 1'b1;
      {n_fail, tests_run, cycles} = {32'h0, 32'h0, 32'h0};
      idle(3);
      rst_n = 1'b1;
      rd(8'h14, 8'h00);
      rd(8'h15, 8'h00);
      rd(8'h0F, 8'h00);
      wr(8'h14, 8'hFF);
      rd(8'h14, 8'hF8);
      wr(8'h14, 8'h00);
      tripped = 2'b01;
      st(8'h04);
      tripped = 2'b00;
      for (int m = 0; m < 4; m++)
      begin
         level = {1'b0, m[0]};
         wr(8'h14, 8'h00);
         wr(8'h14, {2'b11, m[1], m[0], 4'h0});
         st(8'h04);
         tripped = 2'b01;
         st(8'h01);
         tripped = 2'b00;
         st(8'h01);
         rd(8'h0F, 8'h01);
         wr(8'h0F, 8'h00);
         rd(8'h0F, 8'h01);
         wr(8'h14, 8'h40);
         st(8'h04);
      end
      level = 2'b10;
      on_battery = 1'b1;
      wr(8'h15, 8'hD0);
      rd(8'h15, 8'hD0);
      tripped = 2'b10;
      st(8'h06);
      rd(8'h0F, 8'h02);
      wr(8'h0F, 8'h00);
      rd(8'h0F, 8'h02);
      battery_irq_enable = 1'b1;
      st(8'h02);
      tripped = 2'b00;
      wr(8'h15, 8'h00);
      on_battery = 1'b0;
      level = 2'b00;
      wr(8'h14, 8'hC8);
      tripped = 2'b01;
      st(8'h04);
      second_tick = 1'b1;
      idle(1);
      second_tick = 1'b0;
      st(8'h01);
      tripped = 2'b00;
      wr(8'h14, 8'h00);
      osc_running = 1'b0;
      wr(8'h14, 8'hC8);
      tripped = 2'b01;
      st(8'h01);
      tripped = 2'b00;
      wr(8'h14, 8'h00);
      osc_running = 1'b1;
      wr(8'h14, 8'hE8);
      tripped = 2'b01;
      st(8'h01);
      wrap_up();
   end
endmodule

// >>> testbench/tdc_switch_model.sv
// model of the two external tamper switches and their pull resistors
`timescale 1ns/1ps
module tdc_switch_model
(
   // switch state, one bit per channel
   input  wire logic [1:0] tripped,
   input  wire logic [1:0] level,
   // tamper pins
   output logic      [1:0] pin
);
   // idle pin rests at the opposite rail, so a held-over level cannot pass for an event
   assign pin = ~(tripped ^ level);
endmodule
